/* File: pkg/ipc_pkg.sv */
// Purpose: constants and types for the interrupt priority configuration
// Assumes: special function register bus of the core, 8-bit data
// Notes:   bit 7 of both registers is reserved and reads as one
package ipc_pkg;
  localparam int         NUM_SRC        = 7;
  localparam logic [7:0] ADDR_PRIO_LOW  = 8'hB8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hF2;
  localparam logic [7:0] PAGE_PRIO_HIGH = 8'h10;
  localparam logic [7:0] RESET_PRIO     = 8'h80;
  localparam logic [7:0] RSVD_MASK      = 8'h80;
  localparam logic [7:0] FIELD_MASK     = 8'h7F;
  localparam int         RSVD_BIT       = 7;
  // Source bit positions, shared by both registers
  localparam int BIT_SERIAL_PERIPH = 6;
  localparam int BIT_TIMER2        = 5;
  localparam int BIT_SERIAL_PORT   = 4;
  localparam int BIT_TIMER1        = 3;
  localparam int BIT_EXT_INT1      = 2;
  localparam int BIT_TIMER0        = 1;
  localparam int BIT_EXT_INT0      = 0;

  typedef enum logic [1:0] {
    IPC_SEL_NONE = 2'b00,
    IPC_SEL_LOW  = 2'b01,
    IPC_SEL_HIGH = 2'b10
  } ipc_sel_t;

  // One special function register access
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       bit_wr;
    logic [2:0] bit_idx;
    logic       bit_val;
    logic [7:0] wdata;
  } ipc_sfr_req_t;

  typedef logic [1:0] ipc_level_t;
endpackage

/* File: hw/ipc_decode.sv */
// Purpose: address and page decode for the priority registers
// Assumes: page value sampled in the same cycle as the address
// Notes:   low register answers on every page
`timescale 1ns/10ps
module ipc_decode (
  // Access
  input  wire logic [7:0]      page,
  input  wire logic [7:0]      addr,
  // Selection
  output ipc_pkg::ipc_sel_t    sel
);
  wire logic hit_low;
  wire logic hit_high;

  assign hit_low  = (addr == ipc_pkg::ADDR_PRIO_LOW);
  assign hit_high = (addr == ipc_pkg::ADDR_PRIO_HIGH) &&
                    (page == ipc_pkg::PAGE_PRIO_HIGH);
  assign sel = hit_low  ? ipc_pkg::IPC_SEL_LOW  :
               hit_high ? ipc_pkg::IPC_SEL_HIGH : ipc_pkg::IPC_SEL_NONE;
endmodule

/* File: hw/ipc_top.sv */
// Purpose: two priority registers and per-source two-bit levels
// Assumes: single core clock, accesses last one cycle
// Notes:   read data is registered, valid one cycle after request
//
// Summary of operation
// - The low register keeps each source's level LSB in bits 6..0, reset 0.
// - The high register keeps each source's level MSB in bits 6..0, reset 0.
// - Each level is high-register bit over the same low-register bit.
// - The low register sits at 0xB8 on every page and takes bit writes.
// - The high register sits at 0xF2 only when page 0x10 is selected.
`timescale 1ns/10ps
module ipc_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Register access
  input  wire logic                 req_valid,
  input  ipc_pkg::ipc_sfr_req_t     req,
  output logic [7:0]                rdata,
  output logic                      rhit,
  // Priority levels per source
  output ipc_pkg::ipc_level_t       level_serial_periph,
  output ipc_pkg::ipc_level_t       level_timer2,
  output ipc_pkg::ipc_level_t       level_serial_port,
  output ipc_pkg::ipc_level_t       level_timer1,
  output ipc_pkg::ipc_level_t       level_ext_int1,
  output ipc_pkg::ipc_level_t       level_timer0,
  output ipc_pkg::ipc_level_t       level_ext_int0
);
  logic [6:0]         prio_lsb;
  logic [6:0]         prio_msb;
  ipc_pkg::ipc_sel_t  sel;
  wire logic          wr_low;
  wire logic          wr_high;
  wire logic [7:0]    cur_low;
  wire logic [7:0]    cur_high;
  wire logic [7:0]    next_low;
  wire logic [7:0]    next_high;
  wire logic [7:0]    rd_mux;

  // Bit write modifies only the addressed bit of the current value
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input ipc_pkg::ipc_sfr_req_t r);
    logic [7:0] v;
    v = r.bit_wr ? cur : r.wdata;
    if (r.bit_wr) begin
      v[r.bit_idx] = r.bit_val;
    end
    return (v & ipc_pkg::FIELD_MASK) | ipc_pkg::RSVD_MASK;
  endfunction

  ipc_decode u_decode (
    .page (req.page),
    .addr (req.addr),
    .sel  (sel)
  );

  assign cur_low   = {1'b1, prio_lsb};
  assign cur_high  = {1'b1, prio_msb};
  assign wr_low    = req_valid && (req.wr || req.bit_wr) &&
                     (sel == ipc_pkg::IPC_SEL_LOW);
  // Bit writes only reach the bit-addressable low register
  assign wr_high   = req_valid && req.wr && !req.bit_wr &&
                     (sel == ipc_pkg::IPC_SEL_HIGH);
  assign next_low  = merge(cur_low, req);
  assign next_high = merge(cur_high, req);
  assign rd_mux    = (sel == ipc_pkg::IPC_SEL_LOW)  ? cur_low  :
                     (sel == ipc_pkg::IPC_SEL_HIGH) ? cur_high : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prio_lsb <= ipc_pkg::RESET_PRIO[6:0];
    end else if (wr_low) begin
      prio_lsb <= next_low[6:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prio_msb <= ipc_pkg::RESET_PRIO[6:0];
    end else if (wr_high) begin
      prio_msb <= next_high[6:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
      rhit  <= 1'b0;
    end else begin
      rdata <= req_valid ? rd_mux : 8'h00;
      rhit  <= req_valid && (sel != ipc_pkg::IPC_SEL_NONE);
    end
  end

  // Levels registered so outputs come from flops; one cycle behind
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_serial_periph <= 2'h0;
      level_timer2        <= 2'h0;
      level_serial_port   <= 2'h0;
      level_timer1        <= 2'h0;
      level_ext_int1      <= 2'h0;
      level_timer0        <= 2'h0;
      level_ext_int0      <= 2'h0;
    end else begin
      level_serial_periph <= {prio_msb[ipc_pkg::BIT_SERIAL_PERIPH],
                              prio_lsb[ipc_pkg::BIT_SERIAL_PERIPH]};
      level_timer2        <= {prio_msb[ipc_pkg::BIT_TIMER2],
                              prio_lsb[ipc_pkg::BIT_TIMER2]};
      level_serial_port   <= {prio_msb[ipc_pkg::BIT_SERIAL_PORT],
                              prio_lsb[ipc_pkg::BIT_SERIAL_PORT]};
      level_timer1        <= {prio_msb[ipc_pkg::BIT_TIMER1],
                              prio_lsb[ipc_pkg::BIT_TIMER1]};
      level_ext_int1      <= {prio_msb[ipc_pkg::BIT_EXT_INT1],
                              prio_lsb[ipc_pkg::BIT_EXT_INT1]};
      level_timer0        <= {prio_msb[ipc_pkg::BIT_TIMER0],
                              prio_lsb[ipc_pkg::BIT_TIMER0]};
      level_ext_int0      <= {prio_msb[ipc_pkg::BIT_EXT_INT0],
                              prio_lsb[ipc_pkg::BIT_EXT_INT0]};
    end
  end

  a_low_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_low |=> prio_lsb == $past(next_low[6:0]))
    else $error("low register did not take write");

  a_high_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_high |=> prio_msb == $past(next_high[6:0]))
    else $error("high register did not take write");

  a_idle_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    !req_valid |=> !rhit && rdata == 8'h00 &&
                   $stable(prio_lsb) && $stable(prio_msb))
    else $error("registers or read port moved without a request");

  a_high_word: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.wr && !req.bit_wr &&
    req.addr == ipc_pkg::ADDR_PRIO_HIGH &&
    req.page == ipc_pkg::PAGE_PRIO_HIGH
    |=> prio_msb == $past(req.wdata[6:0]))
    else $error("high register missed write on its page");

  a_level_pair: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_timer1 ==
        {$past(prio_msb[ipc_pkg::BIT_TIMER1]),
         $past(prio_lsb[ipc_pkg::BIT_TIMER1])})
    else $error("timer1 level not formed from both registers");

  a_level_spi: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_serial_periph ==
        {$past(prio_msb[ipc_pkg::BIT_SERIAL_PERIPH]),
         $past(prio_lsb[ipc_pkg::BIT_SERIAL_PERIPH])})
    else $error("serial peripheral level not formed from both registers");

  a_level_timer2: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_timer2 ==
        {$past(prio_msb[ipc_pkg::BIT_TIMER2]),
         $past(prio_lsb[ipc_pkg::BIT_TIMER2])})
    else $error("timer2 level not formed from both registers");

  a_level_port: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_serial_port ==
        {$past(prio_msb[ipc_pkg::BIT_SERIAL_PORT]),
         $past(prio_lsb[ipc_pkg::BIT_SERIAL_PORT])})
    else $error("serial port level not formed from both registers");

  a_level_ext1: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_ext_int1 ==
        {$past(prio_msb[ipc_pkg::BIT_EXT_INT1]),
         $past(prio_lsb[ipc_pkg::BIT_EXT_INT1])})
    else $error("external 1 level not formed from both registers");

  a_level_timer0: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_timer0 ==
        {$past(prio_msb[ipc_pkg::BIT_TIMER0]),
         $past(prio_lsb[ipc_pkg::BIT_TIMER0])})
    else $error("timer0 level not formed from both registers");

  a_level_ext0: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 level_ext_int0 ==
        {$past(prio_msb[ipc_pkg::BIT_EXT_INT0]),
         $past(prio_lsb[ipc_pkg::BIT_EXT_INT0])})
    else $error("external 0 level not formed from both registers");

  a_low_any_page: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.wr && !req.bit_wr &&
    req.addr == ipc_pkg::ADDR_PRIO_LOW
    |=> prio_lsb == $past(req.wdata[6:0]))
    else $error("low register missed write on some page");

  a_low_bit_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.bit_wr && req.addr == ipc_pkg::ADDR_PRIO_LOW &&
    req.bit_idx != 3'h7
    |=> prio_lsb[$past(req.bit_idx)] == $past(req.bit_val))
    else $error("bit write on low register failed");

  a_low_bit_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.bit_wr && req.addr == ipc_pkg::ADDR_PRIO_LOW
    |=> ((prio_lsb ^ $past(prio_lsb)) &
         ~(7'h01 << $past(req.bit_idx))) == 7'h00)
    else $error("bit write on low register disturbed other bits");

  a_low_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.addr == ipc_pkg::ADDR_PRIO_LOW
    |=> rhit && rdata == {1'b1, $past(prio_lsb)})
    else $error("low register read wrong");

  a_high_bit_off: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.bit_wr && req.addr == ipc_pkg::ADDR_PRIO_HIGH
    |=> $stable(prio_msb))
    else $error("bit write reached the high register");

  a_high_page: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.addr == ipc_pkg::ADDR_PRIO_HIGH &&
    req.page != ipc_pkg::PAGE_PRIO_HIGH |=> $stable(prio_msb))
    else $error("high register written off its page");

  a_high_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.addr == ipc_pkg::ADDR_PRIO_HIGH &&
    req.page == ipc_pkg::PAGE_PRIO_HIGH
    |=> rhit && rdata == {1'b1, $past(prio_msb)})
    else $error("high register read wrong");

  a_miss_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    req_valid && req.addr != ipc_pkg::ADDR_PRIO_LOW &&
    !(req.addr == ipc_pkg::ADDR_PRIO_HIGH &&
      req.page == ipc_pkg::PAGE_PRIO_HIGH)
    |=> !rhit && rdata == 8'h00 && $stable(prio_lsb) && $stable(prio_msb))
    else $error("unmapped access answered or changed a register");

  a_rsvd_one: assert property (
    @(posedge clk) disable iff (!reset_n)
    rhit |-> rdata[7])
    else $error("reserved bit read as zero");
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the priority registers
// Assumes: rdata/rhit settle one cycle after a taken request
// Notes:   bench keeps its own copy of both registers
`timescale 1ns/10ps
module tb_top;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  req_valid = 1'b0;
  ipc_pkg::ipc_sfr_req_t req = '0;
  logic [7:0]            rdata;
  logic                  rhit;
  ipc_pkg::ipc_level_t   lv [7];
  logic [6:0]            m_lo = 7'h00;
  logic [6:0]            m_hi = 7'h00;
  logic [8:0]            exp_q [$];
  logic                  t1 = 1'b0;
  int                    n_errors = 0;
  int                    samples_checked = 0;
  int                    seed = 32'h5A4F58C6;
  ipc_top dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .rdata(rdata), .rhit(rhit),
    .level_serial_periph(lv[6]), .level_timer2(lv[5]),
    .level_serial_port(lv[4]), .level_timer1(lv[3]),
    .level_ext_int1(lv[2]), .level_timer0(lv[1]), .level_ext_int0(lv[0]));
  always #5 clk = ~clk;
  task automatic check(input string nm, input logic [13:0] e, g);
    samples_checked++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // Read value is taken before the write lands, as the port does
  task automatic op(input logic [7:0] pg, ad, input logic w, bw,
                    input logic [2:0] bi, input logic bv, wd7,
                    input logic [6:0] wd);
    logic lo;
    logic hi;
    lo = (ad === 8'hB8);
    hi = (ad === 8'hF2) && (pg === 8'h10);
    exp_q.push_back({lo | hi, lo ? {1'b1, m_lo} : hi ? {1'b1, m_hi} : 8'h00});
    if (lo && bw && bi != 3'h7) m_lo[bi] = bv;
    else if (lo && w && !bw) m_lo = wd;
    else if (hi && w && !bw) m_hi = wd;
    req_valid <= 1'b1;
    req <= ipc_pkg::ipc_sfr_req_t'{pg, ad, w, bw, bi, bv, {wd7, wd}};
    @(posedge clk);
  endtask
  task automatic idle_check_levels();
    logic [13:0] e;
    logic [13:0] g;
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 7; i++) begin
      e[2*i +: 2] = {m_hi[i], m_lo[i]};
      g[2*i +: 2] = lv[i];
    end
    check("levels", e, g);
    @(posedge clk);
  endtask
  // Answer stands in the cycle after the edge that took the request
  always @(posedge clk) begin
    t1 <= req_valid;
  end
  always @(negedge clk) begin
    if (t1) begin
      if (exp_q.size() == 0) check("queue", 14'h0001, 14'h0000);
      else check("rhit_rdata", exp_q.pop_front(), {rhit, rdata});
    end
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    logic [31:0] r;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    op(8'h00, 8'hB8, 0, 0, 0, 0, 0, 7'h00);
    op(8'h10, 8'hF2, 0, 0, 0, 0, 0, 7'h00);
    op(8'h10, 8'hF2, 1, 0, 0, 0, 0, 7'h7F);
    op(8'h00, 8'hF2, 1, 0, 0, 0, 1, 7'h00);
    op(8'h10, 8'hF2, 0, 1, 3'h2, 0, 1, 7'h00);
    op(8'h3C, 8'hB8, 1, 0, 0, 0, 0, 7'h41);
    op(8'h3C, 8'hB8, 0, 1, 3'h7, 0, 0, 7'h00);
    op(8'h00, 8'hB8, 0, 1, 3'h6, 0, 0, 7'h00);
    op(8'h10, 8'hB8, 0, 0, 0, 0, 0, 7'h00);
    idle_check_levels();
    $display("test directed done");
    for (int k = 0; k < 240; k++) begin
      r = $random(seed);
      op(r[2] ? 8'h10 : r[23:16], r[1:0] == 0 ? 8'hB8 :
         r[1:0] == 1 ? 8'hF2 : r[15:8], r[3], r[4] & r[5], r[8:6],
         r[9], r[31], r[30:24]);
      if (k % 12 == 11) idle_check_levels();
    end
    idle_check_levels();
    $display("test random done");
    report_and_stop();
  end
endmodule
